// >>> hdl/watchdog_timer_unit.sv
`include "wdog_map.svh"
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit
	import wdog_pkg::*;
#(
	parameter int CNT_W = `WD_CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// AXI4-Lite write
	input wire logic [`WD_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [`WD_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Device pins and option area
	input wire logic oscClk,
	input wire logic waitMode,
	input wire logic stopMode,
	input wire logic holdReqN,
	input wire logic resetAck,
	input wire logic [`WD_OPT_W-1:0] optionArea,
	// Watchdog outputs
	output logic wdogIrq,
	output logic sysResetReq,
	output logic protectMode
);
	localparam int SW = 5 + `WD_OPT_W;
	localparam logic [CNT_W-1:0] CNT_FULL = '1;
	// All checks on the system clock, off during reset
	default clocking cbSys @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// Two-flop synchronisers; only stage two is read
	logic [SW-1:0] sync1_q, sync2_q;
	logic oscPrev_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			oscPrev_q <= 1'b0;
		end else begin
			sync1_q <= {optionArea, resetAck, holdReqN, stopMode, waitMode, oscClk};
			sync2_q <= sync1_q;
			oscPrev_q <= sync2_q[0];
		end
	end
	logic oscS, waitS, stopS, holdNS, ackS;
	logic [`WD_OPT_W-1:0] optS;
	assign oscS = sync2_q[0];
	assign waitS = sync2_q[1];
	assign stopS = sync2_q[2];
	assign holdNS = sync2_q[3];
	assign ackS = sync2_q[4];
	assign optS = sync2_q[SW-1:5];
	// Bus slave state
	logic awHave_q, awHave_d, wHave_q, wHave_d, awready_q, awready_d, wready_q, wready_d;
	logic [`WD_ADDR_W-1:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d, wrFire, wrCtrl, wrRefresh;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	// Control state
	wdState_t state_q, state_d;
	logic [1:0] initCnt_q, initCnt_d, oscDiv_q, oscDiv_d;
	logic uaSel_q, uaSel_d, srcSel_q, srcSel_d, busDiv_q, busDiv_d, protect_q, protect_d;
	logic [`WD_OPT_W-1:0] optCap_q, optCap_d;
	// Counter state
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [2:0] oscPre_q, oscPre_d, oscMask;
	logic [6:0] busPre_q, busPre_d;
	logic irq_q, irq_d, rst_q, rst_d, running, halt, oscTick, busTick, tick, underflow;
	// Write side: address and data latched independently
	assign wrFire = awHave_q && wHave_q && !bvalid_q;
	assign wrCtrl = wrFire && (awAddr_q == `WD_OFF_CTRL) && wStrb_q[0];
	assign wrRefresh = wrFire && (awAddr_q == `WD_OFF_REFRESH);
	always_comb begin
		awHave_d = awHave_q;
		awAddr_d = awAddr_q;
		wHave_d = wHave_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		if (s_axi_awvalid && awready_q) begin
			awHave_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			wHave_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (wrFire) begin
			awHave_d = 1'b0;
			wHave_d = 1'b0;
			bvalid_d = 1'b1;
			if (awAddr_q == `WD_OFF_CTRL || awAddr_q == `WD_OFF_REFRESH) begin
				bresp_d = `WD_RESP_OKAY;
			end else begin
				bresp_d = `WD_RESP_SLVERR;
			end
		end
		awready_d = !awHave_d;
		wready_d = !wHave_d;
	end
	// Read side, one outstanding read
	always_comb begin
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = `WD_RESP_OKAY;
			rdata_d = '0;
			if (s_axi_araddr == `WD_OFF_CTRL) begin
				rdata_d[`WD_BIT_UASEL] = uaSel_q;
				rdata_d[`WD_BIT_SRCSEL] = srcSel_q;
				rdata_d[`WD_BIT_BUSDIV] = busDiv_q;
				rdata_d[`WD_BIT_OSCDIV +: 2] = oscDiv_q;
			end else if (s_axi_araddr == `WD_OFF_STATUS) begin
				rdata_d[CNT_W-1:0] = cnt_q;
				rdata_d[`WD_BIT_RUN] = running;
				rdata_d[`WD_BIT_PROT] = protect_q;
				rdata_d[`WD_BIT_RSTREQ] = rst_q;
			end else if (s_axi_araddr == `WD_OFF_OPTION) begin
				rdata_d[`WD_OPT_W-1:0] = optCap_q;
			end else if (s_axi_araddr != `WD_OFF_REFRESH) begin
				rresp_d = `WD_RESP_SLVERR;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			awHave_q <= 1'b0;
			awAddr_q <= '0;
			wHave_q <= 1'b0;
			wData_q <= '0;
			wStrb_q <= '0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= '0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= '0;
		end else begin
			awHave_q <= awHave_d;
			awAddr_q <= awAddr_d;
			wHave_q <= wHave_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d || (!arready_q && !rvalid_q);
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end
	// Control: option load after synchronisers settle, then software writes
	always_comb begin
		state_d = state_q;
		initCnt_d = initCnt_q;
		uaSel_d = uaSel_q;
		srcSel_d = srcSel_q;
		busDiv_d = busDiv_q;
		oscDiv_d = oscDiv_q;
		protect_d = protect_q;
		optCap_d = optCap_q;
		case (state_q)
			ST_INIT: begin
				initCnt_d = initCnt_q + 2'h1;
				if (initCnt_q == `WD_INIT_WAIT) begin
					optCap_d = optS;
					protect_d = !optS[`WD_OPT_START] && !optS[`WD_OPT_PROT];
					if (!optS[`WD_OPT_START]) begin
						srcSel_d = optS[`WD_OPT_SRC] || protect_d;
						busDiv_d = optS[`WD_OPT_BUSDIV];
						oscDiv_d = optS[`WD_OPT_OSCDIV +: 2];
						state_d = ST_RUN;
					end else begin
						state_d = ST_PARK;
					end
				end
			end
			ST_PARK: state_d = wrRefresh ? ST_RUN : ST_PARK;
			default: state_d = ST_RUN;
		endcase
		if (wrCtrl) begin
			uaSel_d = uaSel_q || wData_q[`WD_BIT_UASEL];
			busDiv_d = wData_q[`WD_BIT_BUSDIV];
			oscDiv_d = wData_q[`WD_BIT_OSCDIV +: 2];
			if (state_q != ST_RUN && !protect_q) begin
				srcSel_d = wData_q[`WD_BIT_SRCSEL];
			end
		end
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_INIT;
			initCnt_q <= '0;
			uaSel_q <= 1'b0;
			srcSel_q <= 1'b0;
			busDiv_q <= 1'b0;
			oscDiv_q <= '0;
			protect_q <= 1'b0;
			optCap_q <= '0;
		end else begin
			state_q <= state_d;
			initCnt_q <= initCnt_d;
			uaSel_q <= uaSel_d;
			srcSel_q <= srcSel_d;
			busDiv_q <= busDiv_d;
			oscDiv_q <= oscDiv_d;
			protect_q <= protect_d;
			optCap_q <= optCap_d;
		end
	end
	// Prescalers and counter
	assign running = (state_q == ST_RUN);
	assign halt = !srcSel_q && (waitS || stopS || !holdNS);
	// divide by 1, 2, 4, 8
	assign oscMask = 3'((4'h1 << oscDiv_q) - 4'h1);
	assign oscTick = running && oscS && !oscPrev_q && (oscPre_q == oscMask);
	assign busTick = running && !halt
		&& (busDiv_q ? (busPre_q == `WD_BUS_DIV_HI) : (busPre_q[3:0] == 4'(`WD_BUS_DIV_LO)));
	assign tick = srcSel_q ? oscTick : busTick;
	assign underflow = tick && !wrRefresh && (cnt_q == '0);
	always_comb begin
		oscPre_d = oscPre_q;
		busPre_d = busPre_q;
		cnt_d = cnt_q;
		// prescalers only advance, never cleared here
		if (running && oscS && !oscPrev_q) begin
			oscPre_d = (oscPre_q == oscMask) ? 3'h0 : oscPre_q + 3'h1;
		end
		if (running && !halt) begin
			busPre_d = busPre_q + 7'h01;
		end
		if (wrRefresh || underflow) begin
			cnt_d = CNT_FULL;
		end else if (tick) begin
			cnt_d = cnt_q - 1'b1;
		end
		// underflow action, pulse and held reset
		irq_d = underflow && !uaSel_q;
		rst_d = (underflow && uaSel_q) || (rst_q && !ackS);
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			oscPre_q <= '0;
			busPre_q <= '0;
			cnt_q <= CNT_FULL;
			irq_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			oscPre_q <= oscPre_d;
			busPre_q <= busPre_d;
			cnt_q <= cnt_d;
			irq_q <= irq_d;
			rst_q <= rst_d;
		end
	end
	// Outputs straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wdogIrq = irq_q;
	assign sysResetReq = rst_q;
	assign protectMode = protect_q;
	// Checks
	sequence sRefresh;
		wrRefresh;
	endsequence
	sequence sUnder;
		tick && !wrRefresh && cnt_q == '0;
	endsequence
	AST_LOCK: assert property (uaSel_q |=> uaSel_q) else $error("reset select cleared");
	AST_RELOAD: assert property (sRefresh |=> cnt_q == CNT_FULL) else $error("refresh did not reload");
	AST_UNDIRQ: assert property (sUnder ##0 !uaSel_q |=> wdogIrq && cnt_q == CNT_FULL ##1 !wdogIrq)
		else $error("underflow interrupt wrong");
	AST_UNDRST: assert property (sUnder ##0 uaSel_q |=> sysResetReq && !wdogIrq)
		else $error("underflow reset missing");
	AST_HOLDRST: assert property (sysResetReq && !ackS |=> sysResetReq) else $error("reset dropped early");
	AST_HALT: assert property (running && !srcSel_q && (waitS || stopS || !holdNS) && !wrRefresh |=> $stable(cnt_q))
		else $error("counter moved while halted");
	AST_OSCRUN: assert property (oscTick && srcSel_q && cnt_q != '0 && !wrRefresh |=> cnt_q == $past(cnt_q) - 1'b1)
		else $error("oscillator tick missed");
	AST_SRCLOCK: assert property (running |=> $stable(srcSel_q)) else $error("source changed");
	AST_PARK: assert property (state_q == ST_PARK && !wrRefresh |=> state_q == ST_PARK && cnt_q == CNT_FULL)
		else $error("started without refresh");
	AST_OPTRO: assert property (
		wrFire && awAddr_q == `WD_OFF_OPTION |=> s_axi_bvalid && s_axi_bresp == `WD_RESP_SLVERR)
		else $error("option write not refused");
endmodule
`default_nettype wire

// >>> hdl/wdog_map.svh
// Function
// - 15-bit counter decrements once per prescaler output, bus or oscillator fed.
// - Underflow raises interrupt when action select is 0, reset when 1.
// - Action select once 1 cannot be cleared by software, only reset.
// - Oscillator prescaler divides by 1, 2, 4 or 8 via two-bit field.
// - Bus clock prescaler divides by 16 or 128 via one select bit.
// - Count source select picks bus prescaler or oscillator prescaler.
// - Bus-clocked counting halts in wait, stop, or while hold input low.
// - After halt the counter resumes from its held value, no reload.
// - Oscillator-clocked counting never halts in low-power or hold states.
// - Refresh write or generated interrupt request reinitialises the counter.
// - Prescaler cleared only by device reset, never by refresh or underflow.
// - Start option 1: stay stopped after reset until first refresh write.
// - Start option 0: start counting automatically when reset releases.
// - Source protect mode active only when start and protect options both 0.
// - Once counting starts, writes to count source select are ignored.
// - Start option 0 loads option divider and source settings at reset.
// - Option area cannot be rewritten by the running program.
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH
`define WD_CNT_W 15
`define WD_ADDR_W 8
`define WD_OFF_CTRL 8'h00
`define WD_OFF_REFRESH 8'h04
`define WD_OFF_STATUS 8'h08
`define WD_OFF_OPTION 8'h0C
`define WD_BIT_UASEL 0
`define WD_BIT_SRCSEL 1
`define WD_BIT_BUSDIV 2
`define WD_BIT_OSCDIV 3
`define WD_BIT_RUN 16
`define WD_BIT_PROT 17
`define WD_BIT_RSTREQ 18
`define WD_OPT_START 0
`define WD_OPT_PROT 1
`define WD_OPT_SRC 2
`define WD_OPT_BUSDIV 3
`define WD_OPT_OSCDIV 4
`define WD_OPT_W 6
`define WD_INIT_WAIT 2'h3
`define WD_BUS_DIV_LO 7'h0F
`define WD_BUS_DIV_HI 7'h7F
`define WD_RESP_OKAY 2'h0
`define WD_RESP_SLVERR 2'h2
`endif

// >>> hdl/wdog_pkg.sv
package wdog_pkg;
	// Lifecycle: option load, parked until refresh, counting
	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_PARK = 2'b01,
		ST_RUN = 2'b11
	} wdState_t;
endpackage

// >>> tb/tb_top.sv
`include "wdog_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// Narrow counter keeps underflow runs short
	localparam int CW = 6;
	localparam logic [31:0] FS = 32'h0000_003F;
	logic clk_sys = 1'h0;
	logic resetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [1:0] oscPh = 2'h0;
	logic waitMode = 1'h0;
	logic stopMode = 1'h0;
	logic holdReqN = 1'h1;
	logic resetAck = 1'h0;
	logic [5:0] optionArea = 6'h01;
	logic wdogIrq, sysResetReq, protectMode;
	int n_fail = 0;
	int n_tests = 0;
	int irqSeen = 0;
	int cyc = 0;

	// Clocks; oscillator is two cycles high, two low
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) oscPh <= oscPh + 2'h1;

	watchdog_timer_unit #(.CNT_W(CW)) watchdog_timer_unit_inst (
		.clk_sys, .resetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready,
		.oscClk(oscPh[1]), .waitMode, .stopMode, .holdReqN, .resetAck, .optionArea,
		.wdogIrq, .sysResetReq, .protectMode
	);

	// Pulse counter and hang ceiling
	always @(posedge clk_sys) begin
		cyc++;
		if (wdogIrq === 1'h1) irqSeen++;
		if (cyc == 30000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Options set while reset is low, captured in the cycles after release
	task automatic rst(input logic [5:0] opt);
		resetn <= 1'h0;
		optionArea <= opt;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'h1;
		repeat (6) @(posedge clk_sys);
	endtask

	// Trailing idle edge keeps bready from toggling twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge clk_sys);
			if (!aw && s_axi_awready === 1'h1) begin
				aw = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready === 1'h1) begin
				w = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic cnt(output logic [31:0] c);
		logic [31:0] d;
		logic [1:0] r;
		rd(`WD_OFF_STATUS, d, r);
		c = {17'h0, d[14:0]};
	endtask

	// Decrements over a window, one tick of slack for prescaler phase
	task automatic rate(input int win, input int e, output logic [31:0] ok);
		logic [31:0] a;
		logic [31:0] b;
		int dl;
		cnt(a);
		repeat (win) @(posedge clk_sys);
		cnt(b);
		dl = int'(a) - int'(b);
		ok = {31'h0, dl >= e - 1 && dl <= e + 1};
	endtask

	task automatic t_park();
		logic [31:0] d;
		logic [1:0] r;
		rst(6'h3D);
		rd(`WD_OFF_CTRL, d, r);
		chk(d, 32'h0000_0000);
		rd(`WD_OFF_STATUS, d, r);
		chk(d, FS);
		repeat (100) @(posedge clk_sys);
		rd(`WD_OFF_STATUS, d, r);
		chk(d, FS);
		rd(`WD_OFF_OPTION, d, r);
		chk(d, 32'h0000_003D);
		rd(8'h10, d, r);
		chk({30'h0, r}, 32'h0000_0002);
		wr(`WD_OFF_REFRESH, 32'h0000_0000, r);
		rd(`WD_OFF_STATUS, d, r);
		chk({31'h0, d[16]}, 32'h0000_0001);
	endtask

	// oscillator ratios keep running through every halt
	task automatic t_osc();
		logic [31:0] ok;
		logic [1:0] r;
		{waitMode, stopMode, holdReqN} <= 3'h6;
		for (int d = 0; d < 4; d++) begin
			rst(6'h01);
			wr(`WD_OFF_CTRL, 32'(d * 8 + 2), r);
			wr(`WD_OFF_REFRESH, 32'h0000_0000, r);
			rate(128, 32 >> d, ok);
			chk(ok, 32'h0000_0001);
		end
		wr(`WD_OFF_CTRL, 32'h0000_0000, r);
		rd(`WD_OFF_CTRL, ok, r);
		chk({31'h0, ok[1]}, 32'h0000_0001);
		{waitMode, stopMode, holdReqN} <= 3'h1;
	endtask

	task automatic t_bus();
		logic [31:0] ok;
		logic [1:0] r;
		for (int b = 0; b < 2; b++) begin
			rst(6'h01);
			wr(`WD_OFF_CTRL, 32'(b * 4), r);
			wr(`WD_OFF_REFRESH, 32'h0000_0000, r);
			rate(b == 1 ? 1280 : 160, 10, ok);
			chk(ok, 32'h0000_0001);
		end
	endtask

	task automatic t_halt();
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		logic [1:0] r;
		rst(6'h01);
		wr(`WD_OFF_CTRL, 32'h0000_0000, r);
		wr(`WD_OFF_REFRESH, 32'h0000_0000, r);
		for (int h = 0; h < 3; h++) begin
			{waitMode, stopMode, holdReqN} <= (h == 0) ? 3'h5 : (h == 1) ? 3'h3 : 3'h0;
			repeat (4) @(posedge clk_sys);
			cnt(a);
			repeat (200) @(posedge clk_sys);
			cnt(b);
			chk(b, a);
			{waitMode, stopMode, holdReqN} <= 3'h1;
			repeat (80) @(posedge clk_sys);
			cnt(c);
			chk({31'h0, a - c >= 4 && a - c <= 7}, 32'h0000_0001);
		end
	endtask

	task automatic t_prot();
		logic [31:0] d;
		logic [1:0] r;
		rst(6'h2A);
		chk({31'h0, protectMode}, 32'h0000_0000);
		rd(`WD_OFF_CTRL, d, r);
		chk(d & 32'h0000_001E, 32'h0000_0014);
		rd(`WD_OFF_STATUS, d, r);
		chk({31'h0, d[16]}, 32'h0000_0001);
		rst(6'h28);
		chk({31'h0, protectMode}, 32'h0000_0001);
		rd(`WD_OFF_STATUS, d, r);
		chk({30'h0, d[17:16]}, 32'h0000_0003);
		wr(`WD_OFF_OPTION, 32'h0000_0001, r);
		chk({30'h0, r}, 32'h0000_0002);
		rd(`WD_OFF_OPTION, d, r);
		chk(d, 32'h0000_0028);
	endtask

	task automatic t_under();
		logic [31:0] d;
		logic [1:0] r;
		int n;
		rst(6'h01);
		irqSeen = 0;
		wr(`WD_OFF_CTRL, 32'h0000_0002, r);
		for (int i = 0; i < 5; i++) begin
			repeat (150) @(posedge clk_sys);
			wr(`WD_OFF_REFRESH, 32'h0000_0000, r);
		end
		chk(32'(irqSeen), 32'h0000_0000);
		n = 0;
		while (wdogIrq !== 1'h1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		chk({31'h0, n >= 246 && n <= 262}, 32'h0000_0001);
		@(posedge clk_sys);
		chk({31'h0, wdogIrq}, 32'h0000_0000);
		cnt(d);
		chk({31'h0, d >= FS - 2}, 32'h0000_0001);
		wr(`WD_OFF_CTRL, 32'h0000_0003, r);
		wr(`WD_OFF_CTRL, 32'h0000_0002, r);
		rd(`WD_OFF_CTRL, d, r);
		chk({31'h0, d[0]}, 32'h0000_0001);
		n = 0;
		while (sysResetReq !== 1'h1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		chk({31'h0, n < 400}, 32'h0000_0001);
		chk(32'(irqSeen), 32'h0000_0001);
		repeat (20) @(posedge clk_sys);
		chk({31'h0, sysResetReq}, 32'h0000_0001);
		resetAck <= 1'h1;
		repeat (6) @(posedge clk_sys);
		chk({31'h0, sysResetReq}, 32'h0000_0000);
		resetAck <= 1'h0;
		rst(6'h01);
		rd(`WD_OFF_CTRL, d, r);
		chk({31'h0, d[0]}, 32'h0000_0000);
	endtask

	// Main sequence
	initial begin
		t_park();
		t_osc();
		t_bus();
		t_halt();
		t_prot();
		t_under();
		report_and_stop();
	end
endmodule
`default_nettype wire
